/* File: rtl/baeh_pkg.sv */
// Constants, register map and carrier types of the bridge abort and parity error handler
// What this block does
// - Target-Abort on posted write drops transaction
// - Target-Abort on non-posted returns Completer Abort
// - Target-Abort sets both received-target-abort flags
// - Unmasked error logs header, pointer if invalid
// - Unmasked error sends message by severity, enables
// - Sent message with system enable sets flag
// - Every error sets fatal or nonfatal detected
// - Bad-parity forwarded writes go out poisoned
// - UR on read: abort, or all ones
// - UR on I/O write: abort or normal
// - Completer Abort always answers Target-Abort
// - Write parity error sets detected parity flag
// - Non-posted bad write discarded with PERR when enabled
// - Response disabled: forward poisoned, no PERR
// - Posted bad write asserts PERR when enabled
// - Posted bad write sets master parity flag when enabled
// - Any write parity error sets data error
// - Master-abort mode resets to cleared
package baeh_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_SEC_STATUS = 12'h004;
    localparam logic [11:0] ADDR_UNC_STATUS = 12'h008;
    localparam logic [11:0] ADDR_UNC_MASK = 12'h00c;
    localparam logic [11:0] ADDR_UNC_SEV = 12'h010;
    localparam logic [11:0] ADDR_DEV_STATUS = 12'h014;
    localparam logic [11:0] ADDR_FIRST_ERROR_POINTER = 12'h018;
    localparam logic [11:0] ADDR_HDR_LOG = 12'h01c;
    localparam logic [11:0] ADDR_INT_STATUS = 12'h020;
    localparam logic [11:0] ADDR_INT_MASK = 12'h024;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_SYSTEM_ERROR_ENABLE = 0;
    localparam int CTRL_FATAL_EN = 1;
    localparam int CTRL_NONFATAL_EN = 2;
    localparam int CTRL_PARITY_RESP = 3;
    localparam int CTRL_MA_MODE = 4;
    localparam int SEC_RTA = 0;
    localparam int SEC_DPE = 1;
    localparam int SEC_MDP = 2;
    localparam int SEC_STA = 3;
    localparam int SEC_SSERR = 4;
    localparam int UNC_RTA = 0;
    localparam int UNC_UNCORRECTABLE_DATA_ERROR_FLAG = 1;
    localparam int DEV_FATAL = 0;
    localparam int DEV_NONFATAL = 1;
    localparam int PTR_VALID = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
    // ----------------------------------------
    // Completion status codes
    // ----------------------------------------
    localparam logic [1:0] CPL_SC = 2'h0;
    localparam logic [1:0] CPL_UR = 2'h1;
    localparam logic [1:0] CPL_CA = 2'h2;
    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic posted;
        logic [31:0] header;
    } baeh_abort_t;
    typedef struct packed {
        logic valid;
        logic posted;
        logic [31:0] header;
    } baeh_perr_t;
    typedef struct packed {
        logic valid;
        logic [1:0] status;
        logic is_read;
        logic [31:0] header;
    } baeh_cpl_t;
    typedef struct packed {
        logic drop_posted;
        logic cpl_ca;
        logic fwd_poisoned;
        logic discard_write;
        logic perr;
        logic target_abort;
        logic normal_done;
        logic [31:0] rdata_fill;
        logic msg_valid;
        logic msg_fatal;
    } baeh_resp_t;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [4:0] sec_status;
        logic [1:0] unc_status;
        logic [1:0] unc_mask;
        logic [1:0] unc_sev;
        logic [1:0] dev_status;
        logic [4:0] first_error_pointer;
        logic [31:0] hdr_log;
        logic [1:0] int_status;
        logic [1:0] int_mask;
        logic [31:0] prdata;
        baeh_resp_t resp;
    } baeh_state_t;
endpackage : baeh_pkg

/* File: rtl/baeh_top.sv */
// Error handler for aborts, write parity errors and completion status mapping
module baeh_top (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire baeh_pkg::baeh_abort_t ABORT,
    input wire baeh_pkg::baeh_perr_t PARITY,
    input wire baeh_pkg::baeh_cpl_t CPL,
    output baeh_pkg::baeh_resp_t RESP,
    output logic IRQ
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    baeh_pkg::baeh_state_t r;
    baeh_pkg::baeh_state_t next_r;
    logic wr;
    logic rd;
    logic rd_setup;
    logic mapped;
    logic system_error_enable;
    logic presp;
    logic ma_mode;
    logic [1:0] unc_ev;
    logic [1:0] unmasked;
    logic ev_fatal;
    logic ev_nonfatal;
    logic send;
    logic send_fatal;
    logic [31:0] ev_header;
    logic [4:0] ev_ptr;
    logic [1:0] w1c;
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && PENABLE && !PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    assign mapped = (PADDR[1:0] == 2'h0) && (PADDR <= baeh_pkg::ADDR_INT_MASK);
    assign system_error_enable = r.ctrl[baeh_pkg::CTRL_SYSTEM_ERROR_ENABLE];
    assign presp = r.ctrl[baeh_pkg::CTRL_PARITY_RESP];
    assign ma_mode = r.ctrl[baeh_pkg::CTRL_MA_MODE];
    assign unc_ev = {PARITY.valid, ABORT.valid};
    assign unmasked = unc_ev & ~r.unc_mask;
    assign ev_fatal = |(unc_ev & r.unc_sev);
    assign ev_nonfatal = |(unc_ev & ~r.unc_sev);
    // Message goes out for unmasked errors when a reporting path is enabled
    assign send_fatal = |(unmasked & r.unc_sev);
    assign send = (|unmasked) && (system_error_enable || (send_fatal && r.ctrl[baeh_pkg::CTRL_FATAL_EN]) ||
        (!send_fatal && r.ctrl[baeh_pkg::CTRL_NONFATAL_EN]));
    assign ev_header = unmasked[baeh_pkg::UNC_RTA] ? ABORT.header : PARITY.header;
    assign ev_ptr = unmasked[baeh_pkg::UNC_RTA] ? 5'h00 : 5'h01;
    assign w1c = PWDATA[1:0];

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_r = r;
        next_r.resp = '0;
        next_r.prdata = r.prdata;
        // Downstream Target-Abort handling
        next_r.resp.drop_posted = ABORT.valid && ABORT.posted;
        next_r.resp.cpl_ca = ABORT.valid && !ABORT.posted;
        // Upstream write parity handling
        next_r.resp.perr = PARITY.valid && presp;
        next_r.resp.discard_write = PARITY.valid && !PARITY.posted && presp;
        next_r.resp.fwd_poisoned = PARITY.valid && (PARITY.posted || !presp);
        // Completion status mapping
        if (CPL.valid && CPL.status == baeh_pkg::CPL_CA) begin
            next_r.resp.target_abort = 1'b1;
        end else if (CPL.valid && CPL.status == baeh_pkg::CPL_UR) begin
            if (ma_mode) begin
                next_r.resp.target_abort = 1'b1;
            end else begin
                next_r.resp.normal_done = 1'b1;
                next_r.resp.rdata_fill = CPL.is_read ? baeh_pkg::ALL_ONES : 32'h0000_0000;
            end
        end else if (CPL.valid) begin
            next_r.resp.normal_done = 1'b1;
        end
        next_r.resp.msg_valid = send;
        next_r.resp.msg_fatal = send_fatal;
        // Software side: status and pointer registers except interrupt status write-one-to-clear, set wins over clear
        if (wr && mapped) begin
            case (PADDR)
                baeh_pkg::ADDR_CTRL: next_r.ctrl = PWDATA;
                baeh_pkg::ADDR_SEC_STATUS: next_r.sec_status = r.sec_status & ~PWDATA[4:0];
                baeh_pkg::ADDR_UNC_STATUS: next_r.unc_status = r.unc_status & ~w1c;
                baeh_pkg::ADDR_UNC_MASK: next_r.unc_mask = PWDATA[1:0];
                baeh_pkg::ADDR_UNC_SEV: next_r.unc_sev = PWDATA[1:0];
                baeh_pkg::ADDR_DEV_STATUS: next_r.dev_status = r.dev_status & ~w1c;
                baeh_pkg::ADDR_FIRST_ERROR_POINTER: next_r.first_error_pointer = r.first_error_pointer & ~PWDATA[4:0];
                baeh_pkg::ADDR_INT_MASK: next_r.int_mask = PWDATA[1:0];
                default: next_r.ctrl = r.ctrl;
            endcase
        end
        // Read data loads in the setup phase so it stands at the access edge
        if (rd_setup) begin
            case (PADDR)
                baeh_pkg::ADDR_CTRL: next_r.prdata = r.ctrl;
                baeh_pkg::ADDR_SEC_STATUS: next_r.prdata = {27'h0, r.sec_status};
                baeh_pkg::ADDR_UNC_STATUS: next_r.prdata = {30'h0, r.unc_status};
                baeh_pkg::ADDR_UNC_MASK: next_r.prdata = {30'h0, r.unc_mask};
                baeh_pkg::ADDR_UNC_SEV: next_r.prdata = {30'h0, r.unc_sev};
                baeh_pkg::ADDR_DEV_STATUS: next_r.prdata = {30'h0, r.dev_status};
                baeh_pkg::ADDR_FIRST_ERROR_POINTER: next_r.prdata = {27'h0, r.first_error_pointer};
                baeh_pkg::ADDR_HDR_LOG: next_r.prdata = r.hdr_log;
                baeh_pkg::ADDR_INT_STATUS: next_r.prdata = {30'h0, r.int_status};
                baeh_pkg::ADDR_INT_MASK: next_r.prdata = {30'h0, r.int_mask};
                default: next_r.prdata = 32'h0000_0000;
            endcase
        end
        // Clear only the bits that the read reported, so no event is lost
        if (rd && PADDR == baeh_pkg::ADDR_INT_STATUS) begin
            next_r.int_status = r.int_status & ~r.prdata[1:0];
        end
        // Hardware sets, applied last so a set wins over a clear
        if (ABORT.valid) begin
            next_r.sec_status[baeh_pkg::SEC_RTA] = 1'b1;
            next_r.unc_status[baeh_pkg::UNC_RTA] = 1'b1;
        end
        if (CPL.valid && CPL.status == baeh_pkg::CPL_CA) begin
            next_r.sec_status[baeh_pkg::SEC_RTA] = 1'b1;
        end
        if (next_r.resp.target_abort) begin
            next_r.sec_status[baeh_pkg::SEC_STA] = 1'b1;
        end
        if (PARITY.valid) begin
            next_r.sec_status[baeh_pkg::SEC_DPE] = 1'b1;
            next_r.unc_status[baeh_pkg::UNC_UNCORRECTABLE_DATA_ERROR_FLAG] = 1'b1;
            if (PARITY.posted && presp) begin
                next_r.sec_status[baeh_pkg::SEC_MDP] = 1'b1;
            end
        end
        if (|unmasked && !r.first_error_pointer[baeh_pkg::PTR_VALID]) begin
            next_r.hdr_log = ev_header;
            next_r.first_error_pointer = {1'b1, 4'h0} | ev_ptr;
        end
        if (send && system_error_enable) begin
            next_r.sec_status[baeh_pkg::SEC_SSERR] = 1'b1;
        end
        if (ev_fatal) begin
            next_r.dev_status[baeh_pkg::DEV_FATAL] = 1'b1;
        end
        if (ev_nonfatal) begin
            next_r.dev_status[baeh_pkg::DEV_NONFATAL] = 1'b1;
        end
        next_r.int_status = next_r.int_status | unc_ev;
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            r <= '0;
            r.ctrl <= baeh_pkg::CTRL_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign PRDATA = r.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign RESP = r.resp;
    assign IRQ = |(r.int_status & ~r.int_mask);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_POSTED_DROP: assert property (@(posedge CLK) disable iff (!RST_B)
        ABORT.valid && ABORT.posted |=> RESP.drop_posted && !RESP.cpl_ca)
        else $error("posted abort not dropped");
    AST_NP_CA: assert property (@(posedge CLK) disable iff (!RST_B)
        ABORT.valid && !ABORT.posted |=> RESP.cpl_ca)
        else $error("no completer abort");
    AST_RTA_BOTH: assert property (@(posedge CLK) disable iff (!RST_B)
        ABORT.valid |=> r.sec_status[0] && r.unc_status[0])
        else $error("target abort flags not set");
    AST_PTR_HOLD: assert property (@(posedge CLK) disable iff (!RST_B)
        r.first_error_pointer[4] && !(wr && PADDR == baeh_pkg::ADDR_FIRST_ERROR_POINTER) |=> $stable(r.hdr_log))
        else $error("header log overwritten");
    AST_MSG: assert property (@(posedge CLK) disable iff (!RST_B)
        (|unc_ev) && r.unc_mask == 2'h0 && system_error_enable |=> RESP.msg_valid)
        else $error("error message missing");
    AST_SSERR: assert property (@(posedge CLK) disable iff (!RST_B)
        RESP.msg_valid && $past(system_error_enable) |-> r.sec_status[4])
        else $error("signaled system error not set");
    AST_DEV: assert property (@(posedge CLK) disable iff (!RST_B)
        |unc_ev |=> |r.dev_status)
        else $error("detected flag not set");
    AST_UR_MODE: assert property (@(posedge CLK) disable iff (!RST_B)
        CPL.valid && CPL.status == baeh_pkg::CPL_UR && CPL.is_read && !ma_mode
        |=> RESP.normal_done && RESP.rdata_fill == 32'hffff_ffff)
        else $error("UR read not filled with ones");
    AST_CA_TA: assert property (@(posedge CLK) disable iff (!RST_B)
        CPL.valid && CPL.status == baeh_pkg::CPL_CA |=> RESP.target_abort)
        else $error("completer abort not mapped");
    AST_NP_PERR: assert property (@(posedge CLK) disable iff (!RST_B)
        PARITY.valid && !PARITY.posted && presp |=> RESP.discard_write && RESP.perr
        && !RESP.fwd_poisoned)
        else $error("bad non-posted write not discarded");
    AST_NO_PERR: assert property (@(posedge CLK) disable iff (!RST_B)
        PARITY.valid && !presp |=> !RESP.perr && RESP.fwd_poisoned)
        else $error("PERR with response disabled");
    AST_STICKY: assert property (@(posedge CLK) disable iff (!RST_B)
        r.unc_status[1] && !(wr && PADDR == baeh_pkg::ADDR_UNC_STATUS) |=> r.unc_status[1])
        else $error("flag cleared by hardware");
endmodule : baeh_top

/* File: verification/baeh_far.sv */
// Far-side model: PCI target aborts, PCI write parity errors, PCIe completions
module baeh_far (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic GO,
    input wire logic [1:0] KIND,
    input wire logic POSTED,
    input wire baeh_pkg::baeh_cpl_t INFO,
    output baeh_pkg::baeh_abort_t ABORT,
    output baeh_pkg::baeh_perr_t PARITY,
    output baeh_pkg::baeh_cpl_t CPL
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------
    // One-cycle events; idle headers toggle
    // ----------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ABORT <= '0;
            PARITY <= '0;
            CPL <= '0;
        end else begin
            ABORT <= '{GO && KIND == 2'h0, POSTED, GO ? INFO.header : ~ABORT.header};
            PARITY <= '{GO && KIND == 2'h1, POSTED, GO ? INFO.header : ~PARITY.header};
            CPL <= '{GO && KIND == 2'h2, INFO.status, INFO.is_read,
                GO ? INFO.header : ~CPL.header};
        end
    end
endmodule : baeh_far

/* File: verification/testbench.sv */
// Self-checking bench of the abort and parity error handler
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [4:0] ctrl;
        logic [1:0] kind;
        logic posted;
        logic [1:0] st;
        logic rd;
        baeh_pkg::baeh_resp_t exp;
    } baeh_row_t;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, posted = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, irq, e;
    logic [1:0] kind = 2'h0;
    baeh_pkg::baeh_cpl_t info = '0;
    baeh_pkg::baeh_abort_t abort_ev;
    baeh_pkg::baeh_perr_t parity_ev;
    baeh_pkg::baeh_cpl_t cpl_ev;
    baeh_pkg::baeh_resp_t resp;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    baeh_row_t rows [13] = '{
        '{5'h01, 2'h0, 1'b1, 2'h0, 1'b0, {7'b1000000, 32'h0, 2'b10}},
        '{5'h01, 2'h0, 1'b0, 2'h0, 1'b0, {7'b0100000, 32'h0, 2'b10}},
        '{5'h09, 2'h1, 1'b0, 2'h0, 1'b0, {7'b0001100, 32'h0, 2'b10}},
        '{5'h01, 2'h1, 1'b0, 2'h0, 1'b0, {7'b0010000, 32'h0, 2'b10}},
        '{5'h09, 2'h1, 1'b1, 2'h0, 1'b0, {7'b0010100, 32'h0, 2'b10}},
        '{5'h01, 2'h1, 1'b1, 2'h0, 1'b0, {7'b0010000, 32'h0, 2'b10}},
        '{5'h10, 2'h2, 1'b0, 2'h1, 1'b1, {7'b0000010, 32'h0, 2'b00}},
        '{5'h00, 2'h2, 1'b0, 2'h1, 1'b1, {7'b0000001, 32'hffff_ffff, 2'b00}},
        '{5'h10, 2'h2, 1'b0, 2'h1, 1'b0, {7'b0000010, 32'h0, 2'b00}},
        '{5'h00, 2'h2, 1'b0, 2'h1, 1'b0, {7'b0000001, 32'h0, 2'b00}},
        '{5'h00, 2'h2, 1'b0, 2'h2, 1'b1, {7'b0000010, 32'h0, 2'b00}},
        '{5'h10, 2'h2, 1'b0, 2'h2, 1'b0, {7'b0000010, 32'h0, 2'b00}},
        '{5'h00, 2'h0, 1'b1, 2'h0, 1'b0, {7'b1000000, 32'h0, 2'b00}}};
    baeh_top dut_u (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .ABORT(abort_ev), .PARITY(parity_ev),
        .CPL(cpl_ev), .RESP(resp), .IRQ(irq));
    baeh_far far_u (.CLK(clk), .RST_B(rst_b), .GO(go), .KIND(kind), .POSTED(posted),
        .INFO(info), .ABORT(abort_ev), .PARITY(parity_ev), .CPL(cpl_ev));
    // ----------------
    // Clock, timeout and helpers
    // ----------------
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task final_report();
        if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        e = pslverr;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask : apb
    task ev(input logic [1:0] k, input logic p, input logic [1:0] s, input logic r,
        input logic [31:0] h);
        @(posedge clk);
        go <= 1'b1;
        kind <= k;
        posted <= p;
        info <= '{1'b0, s, r, h};
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
    endtask : ev
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, baeh_pkg::ADDR_CTRL, 32'h0);
        chk(q, baeh_pkg::CTRL_RESET);
        for (int i = 0; i < 13; i++) begin
            apb(1'b1, baeh_pkg::ADDR_CTRL, {27'h0, rows[i].ctrl});
            ev(rows[i].kind, rows[i].posted, rows[i].st, rows[i].rd, 32'hc0de_0000 + i);
            chk(resp, rows[i].exp);
        end
        apb(1'b0, baeh_pkg::ADDR_SEC_STATUS, 32'h0);
        chk(q & 32'h17, 32'h17);
        apb(1'b0, baeh_pkg::ADDR_UNC_STATUS, 32'h0);
        chk(q, 32'h3);
        apb(1'b0, baeh_pkg::ADDR_DEV_STATUS, 32'h0);
        chk(q, 32'h2);
        apb(1'b0, baeh_pkg::ADDR_FIRST_ERROR_POINTER, 32'h0);
        chk(q, 32'h10);
        apb(1'b0, baeh_pkg::ADDR_HDR_LOG, 32'h0);
        chk(q, 32'hc0de_0000);
        chk(irq, 1'b1);
        apb(1'b1, baeh_pkg::ADDR_INT_MASK, 32'h3);
        chk(irq, 1'b0);
        apb(1'b1, baeh_pkg::ADDR_INT_MASK, 32'h0);
        chk(irq, 1'b1);
        apb(1'b0, baeh_pkg::ADDR_INT_STATUS, 32'h0);
        chk(irq, 1'b0);
        apb(1'b1, baeh_pkg::ADDR_SEC_STATUS, 32'h0);
        apb(1'b0, baeh_pkg::ADDR_SEC_STATUS, 32'h0);
        chk(q & 32'h17, 32'h17);
        apb(1'b1, baeh_pkg::ADDR_SEC_STATUS, 32'h1f);
        apb(1'b0, baeh_pkg::ADDR_SEC_STATUS, 32'h0);
        chk(q, 32'h0);
        ev(2'h1, 1'b1, 2'h0, 1'b0, 32'h0bad_0001);
        apb(1'b0, baeh_pkg::ADDR_SEC_STATUS, 32'h0);
        chk(q & 32'h6, 32'h2);
        apb(1'b1, baeh_pkg::ADDR_FIRST_ERROR_POINTER, 32'h1f);
        apb(1'b1, baeh_pkg::ADDR_UNC_MASK, 32'h1);
        apb(1'b1, baeh_pkg::ADDR_CTRL, 32'h1);
        ev(2'h0, 1'b1, 2'h0, 1'b0, 32'h1234_5678);
        chk({resp.drop_posted, resp.msg_valid}, 2'b10);
        apb(1'b0, baeh_pkg::ADDR_FIRST_ERROR_POINTER, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, baeh_pkg::ADDR_UNC_MASK, 32'h0);
        apb(1'b1, baeh_pkg::ADDR_UNC_SEV, 32'h1);
        apb(1'b1, baeh_pkg::ADDR_CTRL, 32'h2);
        ev(2'h0, 1'b0, 2'h0, 1'b0, 32'h5555_aaaa);
        chk({resp.cpl_ca, resp.msg_valid, resp.msg_fatal}, 3'b111);
        apb(1'b0, baeh_pkg::ADDR_SEC_STATUS, 32'h0);
        chk(q & 32'h10, 32'h0);
        apb(1'b0, baeh_pkg::ADDR_DEV_STATUS, 32'h0);
        chk(q, 32'h3);
        apb(1'b0, baeh_pkg::ADDR_HDR_LOG, 32'h0);
        chk(q, 32'h5555_aaaa);
        apb(1'b0, 12'h0fc, 32'h0);
        chk({e, q}, {1'b1, 32'h0});
        // Reset in mid-run clears control and status
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, baeh_pkg::ADDR_CTRL, 32'h0);
        chk(q, baeh_pkg::CTRL_RESET);
        apb(1'b0, baeh_pkg::ADDR_DEV_STATUS, 32'h0);
        chk(q, 32'h0);
        final_report();
    end
endmodule : testbench
